// ==== include/rfrx_regs.svh ====
// register offsets, field positions, reset values and codes of the framing block
`ifndef RFRX_REGS_SVH
`define RFRX_REGS_SVH

`define RFRX_ADDR_RX_LEN_LOW   6'h3b
`define RFRX_ADDR_SETTINGS     6'h3c
`define RFRX_ADDR_TX_HIGH      6'h3d
`define RFRX_ADDR_TX_LOW       6'h3e
`define RFRX_ADDR_FIFO         6'h3f

`define RFRX_MODE_WRITE        2'h0
`define RFRX_MODE_READ         2'h1
`define RFRX_MODE_CMD          2'h2

`define RFRX_CMD_QUERY         8'h98
`define RFRX_CMD_SHORT_LAST    8'h9c
`define RFRX_CMD_LONG          8'h9f
`define RFRX_CMD_TX_PLAIN      8'h90
`define RFRX_CMD_TX_CRC        8'h91

`define RFRX_PRESET_SHORT      8'h10
`define RFRX_PRESET_LONG       8'h20

`define RFRX_BIT_SHORT_CRC     3
`define RFRX_BIT_ALWAYS_CAL    2
`define RFRX_SETTINGS_MASK     8'h0f
`define RFRX_TX_LOW_MASK       8'hfe
`define RFRX_REG_RESET         8'h00

`define RFRX_CRC_SHORT_BITS    5'd5
`define RFRX_CRC_LONG_BITS     5'd16

`define RFRX_FIFO_DEPTH        24
`define RFRX_FIFO_LAST         5'd23
`define RFRX_FIFO_FULL         5'd24
`define RFRX_EMPTY_READ_COUNT  5'h1f

`endif

// ==== include/rfrx_pkg.sv ====
// types of the framing register block
`default_nettype none
`include "rfrx_regs.svh"

package rfrx_pkg;

  typedef enum logic [1:0] {
    spi_idle  = 2'b00,
    spi_addr  = 2'b01,
    spi_write = 2'b10,
    spi_read  = 2'b11
  } rfrx_phase_type;

  typedef struct packed {
    logic [1:0]                                 sclk_sync;
    logic [1:0]                                 ncs_sync;
    logic [1:0]                                 mosi_sync;
    logic                                       sclk_prev;
    logic                                       ncs_prev;
    rfrx_phase_type                             phase;
    logic [2:0]                                 bit_count;
    logic [7:0]                                 shift_in;
    logic [7:0]                                 shift_out;
    logic [5:0]                                 addr;
    logic [7:0]                                 rx_low;
    logic [7:0]                                 settings;
    logic [7:0]                                 tx_high;
    logic [7:0]                                 tx_low;
    logic [1:0][`RFRX_FIFO_DEPTH-1:0][7:0]      mem;
    logic [1:0][4:0]                            wr_ptr;
    logic [1:0][4:0]                            rd_ptr;
    logic [1:0][4:0]                            count;
    logic                                       overflow;
    logic                                       empty_read;
    logic                                       cmd_strobe;
    logic [7:0]                                 cmd_code;
    logic                                       with_calibration;
    logic [1:0]                                 query_session;
  } rfrx_state_type;

  typedef struct packed {
    logic [1:0][7:0] slot;
    logic [1:0]      used;
  } rfrx_buffer_type;

endpackage

`default_nettype wire

// ==== include/rfrx_stream_if.sv ====
// byte stream with valid and ready between the block's modules
`timescale 1ns/1ps
`default_nettype none

interface rfrx_stream_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

`default_nettype wire

// ==== src/rfrx_pair_buffer.sv ====
// two-entry buffer in the transmit byte path
`timescale 1ns/1ps
`default_nettype none

module rfrx_pair_buffer
  import rfrx_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            rst,
  rfrx_stream_if.sink          up,
  rfrx_stream_if.source        down
);

  rfrx_buffer_type state;
  rfrx_buffer_type next_state;
  logic            take;
  logic            give;

  // =========================================================================
  // handshake
  assign up.ready   = state.used != 2'd2;
  assign down.valid = state.used != 2'd0;
  assign down.data  = state.slot[0];
  assign take       = up.valid & up.ready;
  assign give       = down.valid & down.ready;

  // =========================================================================
  // state update
  always_comb
  begin
    next_state = state;
    if (give)
    begin
      next_state.slot[0] = state.slot[1];
      next_state.used    = state.used - 2'd1;
    end
    if (take)
    begin
      next_state.slot[next_state.used[0]] = up.data;
      next_state.used = next_state.used + 2'd1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      state <= '0;
    else
      state <= next_state;
  end

  // =========================================================================
  // checks
  // stalled byte held
  a_buffer_hold: assert property (@(posedge clock) disable iff (rst)
    down.valid && !down.ready |=> down.valid && $stable(down.data))
    else $error("stalled byte changed or vanished");

endmodule

`default_nettype wire

// ==== src/rfrx_framing_regs.sv ====
// transmit and receive framing registers with the two cyclic fifos
// Functional notes
// - commands 98h to 9Ch preset the expected receive length to 16 bits; the code presets only the low byte (3Bh), bits 11 to 8 stay rx_length_high.
// - command 9Fh presets the expected receive length to 32 bits; the code presets only the low byte (3Bh), bits 11 to 8 stay rx_length_high.
// - settings bit 3 picks a 5-bit checksum when set, 16-bit when clear.
// - the query command 98h always sends the calibration period.
// - settings bits 1 and 0 go into the session field of the query.
// - register 3Dh holds transmit byte count bits 11 to 4.
// - upper nibble of register 3Eh holds transmit byte count bits 3 to 0.
// - bits 3 to 1 of register 3Eh give the valid bits of the last byte.
// - two 24-byte fifos sit behind port 3Fh and run cyclically.
// - the unread byte count shows 1Fh after an empty fifo is read.
// - loading more than 24 bytes into a fifo sets the overflow flag.
`timescale 1ns/1ps
`default_nettype none
`include "rfrx_regs.svh"

module rfrx_framing_regs
  import rfrx_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        sclk,
  input  wire logic        spi_select_n,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe,
  input  wire logic [3:0]  rx_length_high,
  output logic [11:0]      rx_expected_length,
  output logic             short_checksum_select,
  output logic [4:0]       checksum_bits,
  output logic             always_send_calibration,
  output logic             session_select_high,
  output logic             session_select_low,
  output logic [11:0]      transmit_byte_count,
  output logic [2:0]       partial_byte_bit_count,
  output logic             command_strobe,
  output logic [7:0]       command_code,
  output logic             frame_with_calibration,
  output logic [1:0]       query_session,
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  output logic [4:0]       unread_fifo_byte_count,
  output logic             fifo_overflow
);

  rfrx_state_type  state;
  rfrx_state_type  next_state;
  logic [1:0]      push;
  logic [1:0]      pop;
  logic [7:0]      byte_in;
  logic            sclk_rise;
  logic            sclk_fall;

  rfrx_stream_if fill_if ();
  rfrx_stream_if drain_if ();

  // =========================================================================
  // decoding helpers
  function automatic logic is_short_preset(input logic [7:0] code);
    return code >= `RFRX_CMD_QUERY && code <= `RFRX_CMD_SHORT_LAST;
  endfunction

  function automatic logic is_long_preset(input logic [7:0] code);
    return code == `RFRX_CMD_LONG;
  endfunction

  function automatic logic [4:0] next_ptr(input logic [4:0] ptr);
    return (ptr == `RFRX_FIFO_LAST) ? 5'd0 : ptr + 5'd1;
  endfunction

  function automatic logic [7:0] read_reg(input logic [5:0]     a,
                                          input rfrx_state_type st);
    unique case (a)
      `RFRX_ADDR_RX_LEN_LOW: return st.rx_low;
      `RFRX_ADDR_SETTINGS:   return st.settings;
      `RFRX_ADDR_TX_HIGH:    return st.tx_high;
      `RFRX_ADDR_TX_LOW:     return st.tx_low;
      `RFRX_ADDR_FIFO:
        return (st.count[1] != 5'd0) ? st.mem[1][st.rd_ptr[1]] : 8'h00;
      default:               return 8'h00;
    endcase
  endfunction

  // =========================================================================
  // serial port edges
  assign sclk_rise = state.sclk_sync[1] & ~state.sclk_prev;
  assign sclk_fall = ~state.sclk_sync[1] & state.sclk_prev;

  // =========================================================================
  // next state
  always_comb
  begin
    logic take;
    logic give;
    take = 1'b0;
    give = 1'b0;
    next_state = state;
    byte_in = {state.shift_in[6:0], state.mosi_sync[1]};
    push = 2'b00;
    pop = 2'b00;
    next_state.sclk_sync = {state.sclk_sync[0], sclk};
    next_state.ncs_sync = {state.ncs_sync[0], spi_select_n};
    next_state.mosi_sync = {state.mosi_sync[0], mosi};
    next_state.sclk_prev = state.sclk_sync[1];
    next_state.ncs_prev = state.ncs_sync[1];
    next_state.cmd_strobe = 1'b0;
    pop[0] = fill_if.valid & fill_if.ready;
    push[1] = rx_valid;
    if (state.ncs_sync[1])
    begin
      next_state.phase = spi_idle;
      next_state.bit_count = 3'd0;
    end
    else if (state.ncs_prev)
    begin
      next_state.phase = spi_addr;
      next_state.bit_count = 3'd0;
    end
    else if (sclk_rise)
    begin
      next_state.shift_in = byte_in;
      next_state.bit_count = state.bit_count + 3'd1;
      if (state.bit_count == 3'd7)
      begin
        unique case (state.phase)
          spi_addr:
          begin
            next_state.addr = byte_in[5:0];
            if (byte_in[7:6] == `RFRX_MODE_CMD)
            begin
              next_state.phase = spi_idle;
              next_state.cmd_strobe = 1'b1;
              next_state.cmd_code = byte_in;
              next_state.overflow = 1'b0;
              next_state.with_calibration = (byte_in == `RFRX_CMD_QUERY)
                | (state.settings[`RFRX_BIT_ALWAYS_CAL]
                   & (byte_in == `RFRX_CMD_TX_PLAIN
                      | byte_in == `RFRX_CMD_TX_CRC));
              if (byte_in == `RFRX_CMD_QUERY)
                next_state.query_session = state.settings[1:0];
              if (is_short_preset(byte_in))
                next_state.rx_low = `RFRX_PRESET_SHORT;
              if (is_long_preset(byte_in))
                next_state.rx_low = `RFRX_PRESET_LONG;
            end
            else if (byte_in[7:6] == `RFRX_MODE_WRITE)
              next_state.phase = spi_write;
            else if (byte_in[7:6] == `RFRX_MODE_READ)
            begin
              next_state.phase = spi_read;
              next_state.shift_out = read_reg(byte_in[5:0], state);
            end
            else
              next_state.phase = spi_idle;
          end
          spi_write:
          begin
            // register and fifo writes, reserved bits held at zero
            unique case (state.addr)
              `RFRX_ADDR_RX_LEN_LOW: next_state.rx_low = byte_in;
              `RFRX_ADDR_SETTINGS:
                next_state.settings = byte_in & `RFRX_SETTINGS_MASK;
              `RFRX_ADDR_TX_HIGH:    next_state.tx_high = byte_in;
              `RFRX_ADDR_TX_LOW:
                next_state.tx_low = byte_in & `RFRX_TX_LOW_MASK;
              `RFRX_ADDR_FIFO:       push[0] = 1'b1;
              default:               next_state.addr = state.addr;
            endcase
          end
          spi_read:
          begin
            // pop the byte just sent, show the next
            pop[1] = state.addr == `RFRX_ADDR_FIFO;
            next_state.shift_out = read_reg(state.addr, state);
            if (pop[1])
              next_state.shift_out = (state.count[1] > 5'd1)
                ? state.mem[1][next_ptr(state.rd_ptr[1])]
                : (push[1] && state.count[1] == 5'd1) ? rx_data : 8'h00;
          end
          spi_idle: next_state.phase = spi_idle;
        endcase
      end
    end
    else if (sclk_fall && state.bit_count != 3'd0
             && state.phase == spi_read)
      next_state.shift_out = {state.shift_out[6:0], 1'b0};

    // cyclic fifo banks, bank 0 transmit, bank 1 receive
    for (int b = 0; b < 2; b++)
    begin
      take = push[b] && state.count[b] != `RFRX_FIFO_FULL;
      give = pop[b] && state.count[b] != 5'd0;
      if (push[b] && !take)
        next_state.overflow = 1'b1;
      if (take)
      begin
        next_state.mem[b][state.wr_ptr[b]] = (b == 0) ? byte_in : rx_data;
        next_state.wr_ptr[b] = next_ptr(state.wr_ptr[b]);
      end
      if (give)
        next_state.rd_ptr[b] = next_ptr(state.rd_ptr[b]);
      next_state.count[b] = state.count[b] + {4'd0, take} - {4'd0, give};
    end

    if (push[1])
      next_state.empty_read = 1'b0;
    if (pop[1] && state.count[1] == 5'd0)
      next_state.empty_read = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state <= '0;
      state.ncs_sync <= 2'b11;
      state.ncs_prev <= 1'b1;
    end
    else
      state <= next_state;
  end

  // =========================================================================
  // transmit path through the pair buffer
  assign fill_if.valid = state.count[0] != 5'd0;
  assign fill_if.data = state.mem[0][state.rd_ptr[0]];
  assign drain_if.ready = tx_ready;
  assign tx_valid = drain_if.valid;
  assign tx_data = drain_if.data;

  rfrx_pair_buffer rfrx_pair_buffer_i (
    .clock (clock),
    .rst   (rst),
    .up    (fill_if),
    .down  (drain_if)
  );

  // =========================================================================
  // outputs
  assign miso = state.shift_out[7];
  assign miso_oe = ~state.ncs_sync[1] & (state.phase == spi_read);
  assign rx_expected_length = {rx_length_high, state.rx_low};
  assign short_checksum_select = state.settings[`RFRX_BIT_SHORT_CRC];
  assign checksum_bits = short_checksum_select ? `RFRX_CRC_SHORT_BITS
                                               : `RFRX_CRC_LONG_BITS;
  assign always_send_calibration = state.settings[`RFRX_BIT_ALWAYS_CAL];
  assign session_select_high = state.settings[1];
  assign session_select_low = state.settings[0];
  assign transmit_byte_count = {state.tx_high, state.tx_low[7:4]};
  assign partial_byte_bit_count = state.tx_low[3:1];
  assign command_strobe = state.cmd_strobe;
  assign command_code = state.cmd_code;
  assign frame_with_calibration = state.with_calibration;
  assign query_session = state.query_session;
  assign unread_fifo_byte_count = state.empty_read ? `RFRX_EMPTY_READ_COUNT
                                                   : state.count[1];
  assign fifo_overflow = state.overflow;

  // =========================================================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_short_preset: assert property (
    command_strobe && is_short_preset(command_code)
      |-> rx_expected_length == {rx_length_high, 8'h10})
    else $error("short command did not preset 16 bits");

  a_long_preset: assert property (
    command_strobe && is_long_preset(command_code)
      |-> rx_expected_length[7:0] == 8'h20 ##1 state.rx_low == 8'h20)
    else $error("command 9Fh did not preset 32 bits");

  a_crc_length: assert property (
    $changed(short_checksum_select)
      |-> checksum_bits == (state.settings[3] ? 5'd5 : 5'd16))
    else $error("checksum length disagrees with settings");

  a_query_cal: assert property (
    command_strobe && command_code == 8'h98 |-> frame_with_calibration)
    else $error("query sent without calibration");

  a_forced_cal: assert property (
    command_strobe && (command_code == 8'h90 || command_code == 8'h91)
      |-> frame_with_calibration == $past(state.settings[2]))
    else $error("data command calibration wrong");

  a_query_session: assert property (
    command_strobe && command_code == 8'h98
      |-> query_session == $past(state.settings[1:0]))
    else $error("query session field wrong");

  a_fifo_fill: assert property (
    push[0] && state.count[0] < 5'd24 && !pop[0]
      |=> state.count[0] == $past(state.count[0]) + 5'd1)
    else $error("transmit fifo count did not advance");

  a_empty_read: assert property (
    pop[1] && state.count[1] == 5'd0 && !push[1]
      |=> unread_fifo_byte_count == 5'h1f)
    else $error("empty read not shown as 1Fh");

  a_overflow_set: assert property (
    (push[0] && state.count[0] == 5'd24)
      || (push[1] && state.count[1] == 5'd24)
      |=> fifo_overflow)
    else $error("overflow flag not set");

endmodule

`default_nettype wire

// ==== verif/rfrx_host_model.sv ====
// serial host model that drives the register port of the framing block
`timescale 1ns/1ps
`default_nettype none

module rfrx_host_model
(
  input  wire logic clock,
  output logic      sclk,
  output logic      spi_select_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  logic [7:0] got [0:31];
  logic       idle_level = 1'b0;
  logic       miso_line;

  // ==========================================================
  // released data line
  // a line nobody drives shows a level that changes every cycle
  assign miso_line = miso_oe ? miso : idle_level;

  always @(posedge clock)
    idle_level <= ~idle_level;

  initial
  begin
    sclk         = 1'b0;
    spi_select_n = 1'b1;
    mosi         = 1'b0;
  end

  // ==========================================================
  // frame tasks
  task automatic wait_clocks(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // data changes on the falling serial edge, sampled on the rising one
  task automatic shift_byte(input logic [7:0] value,
                            output logic [7:0] seen);
    for (int i = 7; i >= 0; i--)
    begin
      mosi = value[i];
      wait_clocks(4);
      sclk = 1'b1;
      seen[i] = miso_line;
      wait_clocks(4);
      sclk = 1'b0;
    end
  endtask

  // one frame: head byte, then n data bytes counting up from first
  task automatic frame(input logic [7:0] head, input int n,
                       input logic [7:0] first);
    logic [7:0] seen;
    wait_clocks(1);
    spi_select_n = 1'b0;
    wait_clocks(4);
    shift_byte(head, seen);
    for (int k = 0; k < n; k++)
      shift_byte(first + 8'(k), got[k]);
    wait_clocks(4);
    spi_select_n = 1'b1;
    mosi = ~mosi;
    wait_clocks(8);
  endtask
endmodule

`default_nettype wire

// ==== verif/rfrx_framing_regs_test.sv ====
// self-checking bench of the framing register block
`timescale 1ns/1ps
`default_nettype none
`include "rfrx_regs.svh"

module rfrx_framing_regs_test;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        sclk, spi_select_n, mosi, miso, miso_oe;
  logic [3:0]  rx_length_high;
  logic [11:0] rx_expected_length, transmit_byte_count;
  logic        short_checksum_select, always_send_calibration;
  logic [4:0]  checksum_bits, unread_fifo_byte_count;
  logic        session_select_high, session_select_low;
  logic [2:0]  partial_byte_bit_count;
  logic        command_strobe, frame_with_calibration, fifo_overflow;
  logic [7:0]  command_code, tx_data, rx_data, v;
  logic [1:0]  query_session;
  logic        tx_valid, tx_ready, rx_valid;
  int          bad_count = 0;
  int          total_checks = 0;
  int          strobes = 0;

  initial
  begin
    forever #25 clock = ~clock;
  end

  always @(posedge clock)
    if (command_strobe === 1'b1)
      strobes <= strobes + 1;

  rfrx_framing_regs rfrx_framing_regs_i (.clock, .rst, .sclk,
    .spi_select_n, .mosi, .miso, .miso_oe, .rx_length_high,
    .rx_expected_length, .short_checksum_select, .checksum_bits,
    .always_send_calibration, .session_select_high, .session_select_low,
    .transmit_byte_count, .partial_byte_bit_count, .command_strobe,
    .command_code, .frame_with_calibration, .query_session, .tx_data,
    .tx_valid, .tx_ready, .rx_data, .rx_valid, .unread_fifo_byte_count,
    .fifo_overflow);

  rfrx_host_model rfrx_host_model_i (.clock, .sclk, .spi_select_n, .mosi,
    .miso, .miso_oe);

  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    rfrx_host_model_i.frame({`RFRX_MODE_WRITE, a}, 1, d);
  endtask

  task automatic rd(input logic [5:0] a, input int n);
    rfrx_host_model_i.frame({`RFRX_MODE_READ, a}, n, 8'h00);
    v = rfrx_host_model_i.got[0];
  endtask

  task automatic push_rx(input logic [7:0] d);
    @(posedge clock);
    #1;
    rx_data = d;
    rx_valid = 1'b1;
    @(posedge clock);
    #1;
    rx_valid = 1'b0;
  endtask

  task automatic issue(input logic [7:0] code, input logic [7:0] preset);
    int n;
    wr(`RFRX_ADDR_RX_LEN_LOW, 8'hff);
    n = strobes;
    rfrx_host_model_i.frame(code, 0, 8'h00);
    check(strobes, n + 1);
    check(command_code, code);
    check(rx_expected_length[7:0], preset);
  endtask

  // ==========================================================
  // scenarios
  task automatic test_reset;
    check(rx_expected_length, 12'h000);
    check(checksum_bits, `RFRX_CRC_LONG_BITS);
    check(fifo_overflow, 1'b0);
    for (int a = 'h3b; a <= 'h3e; a++)
    begin
      rd(a[5:0], 1);
      check(v, `RFRX_REG_RESET);
    end
  endtask

  task automatic test_registers;
    rx_length_high = 4'h9;
    wr(`RFRX_ADDR_RX_LEN_LOW, 8'ha5);
    check(rx_expected_length, 12'h9a5);
    wr(`RFRX_ADDR_SETTINGS, 8'h0d);
    check(short_checksum_select, 1'b1);
    check(checksum_bits, `RFRX_CRC_SHORT_BITS);
    check(always_send_calibration, 1'b1);
    check({session_select_high, session_select_low}, 2'b01);
    wr(`RFRX_ADDR_TX_HIGH, 8'hab);
    wr(`RFRX_ADDR_TX_LOW, 8'hcc);
    check(transmit_byte_count, 12'habc);
    check(partial_byte_bit_count, 3'h6);
    rd(`RFRX_ADDR_TX_LOW, 1);
    check(v, 8'hcc);
    rd(`RFRX_ADDR_SETTINGS, 1);
    check(v, 8'h0d);
    rd(6'h10, 1);
    check(v, 8'h00);
  endtask

  task automatic test_commands;
    for (int c = 'h98; c <= 'h9c; c++)
      issue(c[7:0], `RFRX_PRESET_SHORT);
    issue(`RFRX_CMD_LONG, `RFRX_PRESET_LONG);
    issue(`RFRX_CMD_QUERY, `RFRX_PRESET_SHORT);
    check(frame_with_calibration, 1'b1);
    check(query_session, 2'b01);
    wr(`RFRX_ADDR_SETTINGS, 8'h02);
    check(checksum_bits, `RFRX_CRC_LONG_BITS);
    issue(`RFRX_CMD_QUERY, `RFRX_PRESET_SHORT);
    check(frame_with_calibration, 1'b1);
    check(query_session, 2'b10);
    issue(`RFRX_CMD_TX_PLAIN, 8'hff);
    check(frame_with_calibration, 1'b0);
    wr(`RFRX_ADDR_SETTINGS, 8'h04);
    issue(`RFRX_CMD_TX_CRC, 8'hff);
    check(frame_with_calibration, 1'b1);
  endtask

  task automatic test_tx_fifo;
    int n;
    n = 0;
    rfrx_host_model_i.frame({`RFRX_MODE_WRITE, `RFRX_ADDR_FIFO}, 24, 8'h40);
    check(fifo_overflow, 1'b0);
    check(tx_valid, 1'b1);
    check(tx_data, 8'h40);
    rfrx_host_model_i.frame({`RFRX_MODE_WRITE, `RFRX_ADDR_FIFO}, 3, 8'h58);
    check(fifo_overflow, 1'b1);
    tx_ready = 1'b1;
    for (int i = 0; i < 300 && n < 24; i++)
    begin
      @(negedge clock);
      if (tx_valid === 1'b1)
      begin
        check(tx_data, 8'h40 + 8'(n));
        n++;
      end
    end
    check(n, 24);
    repeat (40) @(posedge clock);
    #1;
    check(tx_valid, 1'b0);
  endtask

  task automatic test_rx_fifo;
    for (int r = 0; r < 2; r++)
    begin
      for (int i = 0; i < 16; i++)
        push_rx(8'h80 + 8'(r * 16 + i));
      check(unread_fifo_byte_count, 5'd16);
      rd(`RFRX_ADDR_FIFO, 16);
      for (int i = 0; i < 16; i++)
        check(rfrx_host_model_i.got[i], 8'h80 + 8'(r * 16 + i));
      check(unread_fifo_byte_count, 5'd0);
    end
    rd(`RFRX_ADDR_FIFO, 1);
    check(v, 8'h00);
    check(unread_fifo_byte_count, `RFRX_EMPTY_READ_COUNT);
    push_rx(8'h11);
    check(unread_fifo_byte_count, 5'd1);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    rx_length_high = 4'h0;
    tx_ready = 1'b0;
    rx_data = 8'h00;
    rx_valid = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    test_reset;
    test_registers;
    test_commands;
    test_tx_fifo;
    test_rx_fifo;
    results;
  end

  initial
  begin
    #3000000;
    bad_count++;
    results;
  end
endmodule

`default_nettype wire
